// >>> logic/bfl_lockout.sv
// battery fault lockout: gate disable, fault flag, report suppression
// operating notes
// - every asynchronous level (battery comparators, chip-select, strap and
//   drain comparators) passes a two-flop synchroniser before any logic
//   reads it, so a pin change reaches the outputs three cycles later
// - gate_command comes from logic on this clock and is not synchronised;
//   it reaches the drives one cycle later
// - either battery fault forces every drive off and masks load faults;
//   the drives and reporting come back by themselves once it clears
// - the fault flag is a sticky level: any present fault sets it, and only
//   a chip-select fall with no fault present clears it; set wins a tie
// - battery faults never enter the serial fault word; that word holds the
//   masked load faults sampled at the chip-select fall and holds them
//   until the next fall
// - chip-select is synchronised inverted so that the synchroniser reset
//   value matches an idle (high) pin; otherwise the first cycle after reset
//   would show a false chip-select fall and clear the flag and the word
// - load faults are taken from the commanded state, not from the drive
//   actually applied: commanded on with drain above the reference is a
//   short, commanded off with drain not above the reference is an open
// - the open-drain flag pin is modelled as a level plus an enable; the
//   enable is high while the pin is pulled low
// - limitation: chip-select falls closer than two cycles apart may merge
//   in the synchroniser and be seen as one fall
// - limitation: a battery pulse shorter than a cycle may be missed by the
//   synchroniser; the analogue comparators are expected to hold their
//   level for far longer than that
// - reset drives every output low, including load_report_en, which comes
//   up one cycle after reset even with a battery fault at the pin, as the
//   battery synchroniser resets to no fault
//
`timescale 1ns/1ps
`include "bfl_map.svh"
module bfl_lockout (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              over_batt_cmp,     // async, high above upper limit
   input  wire logic              under_batt_cmp,    // async, high below lower limit
   input  wire logic              cs_n,              // async chip-select, active low
   input  wire bfl_pkg::bfl_chan_t gate_command,     // same-clock commanded drive state
   input  wire bfl_pkg::bfl_chan_t drain_above_int,  // async, drain above internal ref
   input  wire bfl_pkg::bfl_chan_t drain_above_ext,  // async, drain above external ref
   input  wire logic              ext_ref_select,    // strap, high selects external ref
   output logic                   fault_flag_out,    // open-drain driven low when set
   output logic                   fault_flag_oe,     // high while the pin is pulled low
   output bfl_pkg::bfl_chan_t     fet_drive_outputs, // gate drives
   output bfl_pkg::bfl_chan_t     fault_word,        // serial fault word, bits 0-3
   output logic                   load_report_en     // load fault reporting enabled
);
   import bfl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers
   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]  batt_sync;   // {under, over} after two flops
   logic [9:0]  misc_sync;   // cs, strap, drain comparators

   bfl_sync #(.WIDTH(2)) u_batt_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({under_batt_cmp, over_batt_cmp}),
      .sync_out (batt_sync)
   );

   // chip-select enters inverted so the reset value '0 means idle high
   bfl_sync #(.WIDTH(10)) u_misc_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({~cs_n, ext_ref_select, drain_above_ext, drain_above_int}),
      .sync_out (misc_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decoded conditions
   ////////////////////////////////////////////////////////////////////////////
   wire       over_s   = batt_sync[0];        // over-battery present
   wire       under_s  = batt_sync[1];        // under-battery present
   wire       cs_s     = ~misc_sync[9];       // synchronised chip-select, idle high
   wire       strap_s  = misc_sync[8];        // synchronised strap
   wire [3:0] ext_s    = misc_sync[7:4];      // drain above external ref
   wire [3:0] int_s    = misc_sync[3:0];      // drain above internal ref
   wire       batt_flt = over_s | under_s;    // any battery fault

   logic      cs_d;                           // chip-select one cycle back
   wire       cs_fall  = cs_d & ~cs_s;        // high-to-low chip-select

   // battery state for the drive gate
   bfl_batt_e batt_state;
   assign batt_state = over_s ? BFL_OVER : (under_s ? BFL_UNDER : BFL_NORMAL);

   // reference choice per strap
   wire [3:0] drain_above = strap_s ? ext_s : int_s;

   // load faults: on-state drain high is short, off-state drain low is open
   bfl_chan_t load_flt;
   genvar g;
   generate
      for (g = 0; g < `BFL_CHANNELS; g++) begin : g_chan
         assign load_flt[g] = gate_command[g] ? drain_above[g] : ~drain_above[g];
      end
   endgenerate

   // reporting gated off during any battery fault, back on once clear
   wire       next_report_en = ~batt_flt;
   wire [3:0] rep_flt        = load_flt & {4{next_report_en}};

   // drives follow command only with no battery fault
   bfl_chan_t next_drive;
   always_comb begin
      case (batt_state)
         BFL_OVER:  next_drive = 4'h0;
         BFL_UNDER: next_drive = 4'h0;
         default:   next_drive = gate_command;
      endcase
   end

   // flag sets on any fault, clears on cs fall only when none present; set wins
   wire any_flt   = batt_flt | (|rep_flt);
   wire next_flag = any_flt ? 1'b1 :
                    (cs_fall ? 1'b0 : fault_flag_out);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   ////////////////////////////////////////////////////////////////////////////
   // chip-select history
   always_ff @(posedge clk) begin
      if (rst) cs_d <= 1'b1;
      else     cs_d <= cs_s;
   end

   // drive and reporting enable
   always_ff @(posedge clk) begin
      if (rst) begin
         fet_drive_outputs <= `BFL_GATE_RESET_VAL;
         load_report_en    <= 1'b0;
      end else begin
         fet_drive_outputs <= next_drive;
         load_report_en    <= next_report_en;
      end
   end

   // fault flag
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_flag_out <= `BFL_FLAG_RESET_VAL;
         fault_flag_oe  <= `BFL_FLAG_RESET_VAL;
      end else begin
         fault_flag_out <= next_flag;
         fault_flag_oe  <= next_flag;
      end
   end

   // serial fault word: load faults only, captured at cs fall
   always_ff @(posedge clk) begin
      if (rst)          fault_word <= `BFL_WORD_RESET_VAL;
      else if (cs_fall) fault_word <= rep_flt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   ////////////////////////////////////////////////////////////////////////////
   property p_over_off;
      @(posedge clk) disable iff (rst) over_s |=> fet_drive_outputs == 4'h0;
   endproperty
   a_over_off: assert property (p_over_off) else $error("drive on in over-battery");

   property p_resume;
      @(posedge clk) disable iff (rst) !batt_flt |=> fet_drive_outputs == $past(gate_command);
   endproperty
   a_resume: assert property (p_resume) else $error("drive not following command");

   property p_over_flag;
      @(posedge clk) disable iff (rst) over_s |=> fault_flag_out && fault_flag_oe;
   endproperty
   a_over_flag: assert property (p_over_flag) else $error("no flag on over-battery");

   // pin enable always mirrors the flag level
   property p_oe_track;
      @(posedge clk) disable iff (rst) fault_flag_oe == fault_flag_out;
   endproperty
   a_oe_track: assert property (p_oe_track) else $error("flag enable mismatch");

   // drives return to command once over-battery clears
   property p_over_resume;
      @(posedge clk) disable iff (rst)
         $fell(over_s) && !under_s |=> fet_drive_outputs == $past(gate_command);
   endproperty
   a_over_resume: assert property (p_over_resume) else $error("no resume after over");

   // drives return to command once under-battery clears
   property p_under_resume;
      @(posedge clk) disable iff (rst)
         $fell(under_s) && !over_s |=> fet_drive_outputs == $past(gate_command);
   endproperty
   a_under_resume: assert property (p_under_resume) else $error("no resume after under");

   // under-battery masks load fault reporting
   property p_under_suppress;
      @(posedge clk) disable iff (rst) under_s |=> !load_report_en;
   endproperty
   a_under_suppress: assert property (p_under_suppress) else $error("report on under");

   // under-battery never enters the fault word
   property p_under_word;
      @(posedge clk) disable iff (rst) cs_fall && under_s |=> fault_word == 4'h0;
   endproperty
   a_under_word: assert property (p_under_word) else $error("under in fault word");

   // word bits are the per-channel load faults when no battery fault
   property p_word_bits;
      @(posedge clk) disable iff (rst)
         cs_fall && !batt_flt |=> fault_word == $past(load_flt);
   endproperty
   a_word_bits: assert property (p_word_bits) else $error("fault word bits wrong");

   // strap picks which comparator set is used
   property p_ref_sel;
      @(posedge clk) disable iff (rst) drain_above == (strap_s ? ext_s : int_s);
   endproperty
   a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong");

   // flag holds with no fault and no chip-select fall
   property p_flag_hold;
      @(posedge clk) disable iff (rst)
         !any_flt && !cs_fall |=> fault_flag_out == $past(fault_flag_out);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag changed by itself");

   // a reported load fault raises the flag
   property p_load_flag;
      @(posedge clk) disable iff (rst) |rep_flt |=> fault_flag_out;
   endproperty
   a_load_flag: assert property (p_load_flag) else $error("no flag on load fault");

   property p_word_clean;
      @(posedge clk) disable iff (rst) cs_fall && batt_flt |=> fault_word == 4'h0;
   endproperty
   a_word_clean: assert property (p_word_clean) else $error("battery in fault word");

   property p_suppress;
      @(posedge clk) disable iff (rst) batt_flt |=> !load_report_en;
   endproperty
   a_suppress: assert property (p_suppress) else $error("reporting not suppressed");

   property p_clear;
      @(posedge clk) disable iff (rst) cs_fall && !any_flt |=> !fault_flag_out;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared on cs fall");

   property p_under_off;
      @(posedge clk) disable iff (rst) under_s |=> fet_drive_outputs == 4'h0;
   endproperty
   a_under_off: assert property (p_under_off) else $error("drive on in under-battery");

   property p_under_flag;
      @(posedge clk) disable iff (rst) under_s |=> fault_flag_out;
   endproperty
   a_under_flag: assert property (p_under_flag) else $error("no flag on under-battery");

   property p_hold;
      @(posedge clk) disable iff (rst) !cs_fall |=> $stable(fault_word);
   endproperty
   a_hold: assert property (p_hold) else $error("fault word changed outside cs fall");

   property p_reenable;
      @(posedge clk) disable iff (rst) $fell(batt_flt) |-> ##1 load_report_en;
   endproperty
   a_reenable: assert property (p_reenable) else $error("reporting not re-enabled");
endmodule : bfl_lockout

// >>> logic/bfl_map.svh
// channel count, synchroniser depth and reset values for the battery fault lockout block
`ifndef BFL_MAP_SVH
`define BFL_MAP_SVH
`define BFL_CHANNELS         4
`define BFL_SYNC_STAGES      2
`define BFL_FLAG_RESET_VAL   1'b0
`define BFL_WORD_RESET_VAL   4'h0
`define BFL_GATE_RESET_VAL   4'h0
`endif

// >>> logic/bfl_pkg.sv
// types shared by the battery fault lockout block
package bfl_pkg;
   typedef logic [3:0] bfl_chan_t;   // one bit per output channel
   typedef enum logic [1:0] {
      BFL_NORMAL,
      BFL_OVER,
      BFL_UNDER
   } bfl_batt_e;
endpackage : bfl_pkg

// >>> logic/bfl_sync.sv
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module bfl_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;   // first stage, read only by the second

   // two stage capture
   always_ff @(posedge clk) begin
      if (rst) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule : bfl_sync

// >>> verification/bfl_mcu.sv
// microcontroller model: chip-select strobe and open-drain fault flag pin
`timescale 1ns/1ps
module bfl_mcu (
   input  wire logic clk,
   input  wire logic go,
   input  wire logic fault_flag_oe,
   output logic      cs_n,
   output logic      flag_pin
);
   int hold = 0;  // cycles left with chip-select low
   // board pull-up: pin is low only while the device drives it
   assign flag_pin = fault_flag_oe ? 1'b0 : 1'b1;
   initial cs_n = 1'b1;
   ////////////////////////////////////////////////////////////////
   // one request gives chip-select low for four cycles
   always @(negedge clk) begin
      if (go && cs_n) begin
         cs_n <= 1'b0;
         hold <= 4;
      end else if (!cs_n) begin
         hold <= hold - 1;
         if (hold == 1) cs_n <= 1'b1;
      end
   end
endmodule : bfl_mcu

// >>> verification/tb_top.sv
// self-checking bench for the battery fault lockout block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
   import bfl_pkg::*;
   logic      clk = 0, rst = 1, ov = 0, un = 0, sel = 0, go = 0;  // drives
   bfl_chan_t cmd = '0, da = '1, de = '1;   // loads start faultless
   logic      cs_n, flag, oe, pin, rep;     // observed levels
   bfl_chan_t drv, word;                    // observed words
   int        n_mismatch = 0, comparisons = 0;
   logic      m_flag, batt;                 // model flag and battery fault
   bfl_chan_t ld;                           // model load faults
   always #2.5 clk = ~clk;
   bfl_lockout i_dut (.clk(clk), .rst(rst), .over_batt_cmp(ov), .under_batt_cmp(un),
      .cs_n(cs_n), .gate_command(cmd), .drain_above_int(da), .drain_above_ext(de),
      .ext_ref_select(sel), .fault_flag_out(flag), .fault_flag_oe(oe),
      .fet_drive_outputs(drv), .fault_word(word), .load_report_en(rep));
   bfl_mcu i_mcu (.clk(clk), .go(go), .fault_flag_oe(oe), .cs_n(cs_n), .flag_pin(pin));
   ////////////////////////////////////////////////////////////////
   // verdict and end of run
   task test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // let synchronisers and output flops settle
   task settle;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask : settle
   ////////////////////////////////////////////////////////////////
   // battery modes cycle normal, over, under with random loads
   initial begin
      void'($urandom(32'hdf97));
      repeat (3) @(negedge clk);
      rst = 0;
      settle();
      for (int i = 0; i < 15; i++) begin
         ov  = (i % 3 == 1);
         un  = (i % 3 == 2);
         cmd = bfl_chan_t'($urandom);
         da  = bfl_chan_t'($urandom);
         de  = bfl_chan_t'($urandom);
         sel = 1'($urandom);  // board strap
         // every fifth pass has clean loads so the flag may clear
         if (i % 5 == 0) begin
            da = ~cmd;
            de = ~cmd;
         end
         batt = ov | un;
         ld = (cmd & (sel ? de : da)) | (~cmd & ~(sel ? de : da));
         settle();
         `CHK("drives", batt ? 4'h0 : cmd, drv)
         `CHK("report_en", ~batt, rep)
         if (batt) `CHK("flag_batt", 1'b1, flag)
         go <= 1'b1;
         @(negedge clk) go <= 1'b0;
         settle();
         m_flag = batt | (|ld);
         `CHK("word", batt ? 4'h0 : ld, word)
         `CHK("flag_cs", m_flag, flag)
         `CHK("flag_pin", ~m_flag, pin)
      end
      test_done();
   end
   // watchdog against a hang
   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end
endmodule : tb_top
